// ==== icl_checker.sv ====
/* icl_checker: timing of handshake and answers on the link.
   Assumes the link signals of one clock domain. */
`timescale 1ns/10ps
module icl_checker (
   // clock and reset
   input wire logic       clock_i,
   input wire logic       resetn_i,
   // link
   input wire logic       req_valid,
   input wire logic       req_ready,
   input wire logic       req_write,
   input wire logic       req_spi,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_data,
   input wire logic       resp_valid,
   input wire logic [7:0] resp_data
);
   import icl_pkg::*;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // taken request, taken read
   wire tk = req_valid && req_ready;
   wire rd = tk && !req_write;
   sequence one_byte;
      !resp_valid ##1 resp_valid ##1 !resp_valid;
   endsequence
   a_access_wait: assert property ($rose(resetn_i) |-> !req_ready [*8])
      else $error("early ready");
   a_take_drops: assert property (tk |=> !req_ready)
      else $error("ready held");
   a_write_back: assert property (tk && req_write && req_addr != REG_POWER_CONFIGURATION_REGISTER |-> ##2 req_ready)
      else $error("ready late");
   a_i2c_read: assert property (rd && !req_spi |=> one_byte)
      else $error("i2c answer");
   a_spi_dummy: assert property (rd && req_spi |-> ##2 resp_valid && resp_data == DUMMY_BYTE)
      else $error("spi dummy");
   a_part_id: assert property (rd && !req_spi && req_addr == REG_PART_ID
      |-> ##2 resp_data == PART_ID_VALUE)
      else $error("part id");
   a_settle_wait: assert property (tk && req_write && req_addr == REG_POWER_CONFIGURATION_REGISTER |=> !tk [*8])
      else $error("no settle");
   a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(req_addr))
      else $error("request dropped");
endmodule

// ==== icl_device.sv ====
/*
 icl_device: start-up sequencer and config loader of the sensor device.
 Assumes a host on icl_link_if.dev that holds each request until ready.
*/
`timescale 1ns/10ps
module icl_device #(
   parameter int         PAYLOAD_BYTES = icl_pkg::PAYLOAD_BYTES,
   parameter int         ACCESS_CYC    = icl_pkg::ACCESS_DELAY_CYC,
   parameter int         FINALIZE_CYC  = icl_pkg::FINALIZE_CYC,
   parameter logic [7:0] PART_ID       = icl_pkg::PART_ID_VALUE // arbitrary value
)(
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              resetn_i,
   // host link
   icl_link_if.dev                link,
   // device state
   output icl_pkg::icl_mode_t     mode_o,
   output logic                   power_save_o,
   output logic                   spi_mode_o,
   output logic                   config_done_o,
   output logic [7:0]             pwr_ctrl_o
);
   import icl_pkg::*;

   localparam int PW = $clog2(PAYLOAD_BYTES);

   // refuse parameters the counters cannot hold
   if (PAYLOAD_BYTES < 2 || (1 << PW) != PAYLOAD_BYTES || PW > 17
       || ACCESS_CYC < 1 || ACCESS_CYC > 65535
       || FINALIZE_CYC < 1 || FINALIZE_CYC >= INIT_LIMIT_CYC)
   begin : g_bad_param
      $error("icl_device: unsupported parameter value");
   end

   icl_mode_t    mode;
   logic         power_save;
   logic         spi_mode;
   logic         committed;
   logic         result_ok;
   logic [3:0]   result;
   logic [7:0]   load_ctrl;
   logic [7:0]   pwr_ctrl;
   logic [7:0]   addr_lo;
   logic [7:0]   addr_hi;
   logic [7:0]   time_low;
   logic [9:0]   tick_cnt;
   logic [15:0]  hold_cnt;
   logic [19:0]  fin_cnt;
   logic [PW-1:0] ptr;
   logic [7:0]   mem [PAYLOAD_BYTES];
   logic         dum_left;
   logic         dat_left;
   logic [7:0]   rd_hold;
   logic         req_ready_q;
   logic         resp_valid_q;
   logic [7:0]   resp_data_q;

   // request decode
   wire accept    = link.req_valid & req_ready_q;
   wire wr        = accept & link.req_write;
   wire rd        = accept & ~link.req_write;
   wire sel_read  = rd & link.req_spi & ~spi_mode;
   wire hit_time  = link.req_addr == REG_TIME_LOW;
   wire hit_res   = link.req_addr == REG_RESULT;
   wire hit_pcfg  = link.req_addr == REG_POWER_CONFIGURATION_REGISTER;
   wire hit_ctrl  = link.req_addr == REG_LOAD_CTRL;
   wire hit_alo   = link.req_addr == REG_ADDR_LO;
   wire hit_ahi   = link.req_addr == REG_ADDR_HI;
   wire hit_part  = link.req_addr == REG_PART_ID;
   wire hit_data  = link.req_addr == REG_DATA;
   wire hit_pctl  = link.req_addr == REG_PWR_CTRL;
   wire hold_done = hold_cnt == 16'h0000;
   wire ps_clear  = wr & hit_pcfg & ~link.req_data[0] & power_save;
   wire prep_wr   = wr & hit_ctrl & (link.req_data == LOAD_PREPARE);
   wire commit_wr = wr & hit_ctrl & (link.req_data == LOAD_COMMIT);
   wire data_wr   = wr & hit_data & (mode == ICL_LOADING);
   // reads other than the SPI select read step the pointer in any mode, writes only while loading
   wire data_step = hit_data & (data_wr | (rd & ~sel_read));
   wire [15:0] off_lo = {addr_hi, link.req_data};
   wire [15:0] off_hi = {link.req_data, addr_lo};

   // read-back selection
   wire [7:0] rd_sel =
      hit_part ? PART_ID :
      hit_res  ? {4'h0, result} :
      hit_time ? time_low :
      hit_pcfg ? {7'h00, power_save} :
      hit_ctrl ? load_ctrl :
      hit_alo  ? addr_lo :
      hit_ahi  ? addr_hi :
      hit_data ? mem[ptr] :
      hit_pctl ? pwr_ctrl : 8'h00;

   assign link.req_ready  = req_ready_q;
   assign link.resp_valid = resp_valid_q;
   assign link.resp_data  = resp_data_q;
   assign mode_o          = mode;
   assign power_save_o    = power_save;
   assign spi_mode_o      = spi_mode;
   assign config_done_o   = result_ok;
   assign pwr_ctrl_o      = pwr_ctrl;

   // access hold: power-up delay, restarted when power save is left
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         hold_cnt <= 16'(ACCESS_CYC);
      else if (ps_clear)
         hold_cnt <= 16'(ACCESS_CYC);
      else if (!hold_done)
         hold_cnt <= hold_cnt - 16'h0001;
   end

   // free-running time counter, low byte visible to the host
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         tick_cnt <= 10'h000;
         time_low <= 8'h00;
      end
      else if (tick_cnt == 10'(TIME_TICK_CYC - 1))
      begin
         tick_cnt <= 10'h000;
         time_low <= time_low + 8'h01;
      end
      else
         tick_cnt <= tick_cnt + 10'h001;
   end

   // plain configuration registers
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         power_save <= PWR_SAVE_RST;
         pwr_ctrl   <= PWR_CTRL_RST;
         load_ctrl  <= LOAD_PREPARE;
         addr_lo    <= 8'h00;
         addr_hi    <= 8'h00;
      end
      else if (wr)
      begin
         if (hit_pcfg)
            power_save <= link.req_data[0];
         if (hit_pctl && mode == ICL_CONFIG)
            pwr_ctrl <= link.req_data;
         if (hit_ctrl)
            load_ctrl <= link.req_data;
         if (hit_alo)
            addr_lo <= link.req_data;
         if (hit_ahi)
            addr_hi <= link.req_data;
      end
   end

   // payload pointer: word offset times two, then byte steps
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ptr <= '0;
      else if (wr && hit_alo)
         ptr <= PW'({off_lo, 1'b0});
      else if (wr && hit_ahi)
         ptr <= PW'({off_hi, 1'b0});
      else if (prep_wr)
         ptr <= '0;
      else if (data_step)
         ptr <= ptr + PW'(1);
   end

   // payload storage, no reset needed
   always_ff @(posedge clock_i)
   begin
      if (data_wr)
         mem[ptr] <= link.req_data;
   end

   // load sequencer: suspend, loading, finalize, configuration
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mode      <= ICL_SUSPEND;
         committed <= 1'b0;
         result    <= RESULT_NONE;
         result_ok <= 1'b0;
         fin_cnt   <= 20'h0_0000;
      end
      else
      begin
         case (mode)
            ICL_SUSPEND:
               if (prep_wr && !committed)
               begin
                  mode   <= ICL_LOADING;
                  result <= RESULT_NONE;
               end
            ICL_LOADING:
               // a second commit is never honoured
               if (commit_wr && !committed)
               begin
                  mode      <= ICL_FINALIZE;
                  committed <= 1'b1;
                  fin_cnt   <= 20'(FINALIZE_CYC);
               end
            ICL_FINALIZE:
               if (fin_cnt == 20'h0_0001)
               begin
                  mode      <= ICL_CONFIG;
                  result    <= RESULT_OK;
                  result_ok <= 1'b1;
               end
               else
                  fin_cnt <= fin_cnt - 20'h0_0001;
            ICL_CONFIG:
               mode <= ICL_CONFIG;
            default:
               mode <= ICL_SUSPEND;
         endcase
      end
   end

   // answer path: dummy byte on SPI reads, then data except after the select read
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         spi_mode     <= 1'b0;
         dum_left     <= 1'b0;
         dat_left     <= 1'b0;
         rd_hold      <= 8'h00;
         resp_valid_q <= 1'b0;
         resp_data_q  <= 8'h00;
      end
      else if (rd)
      begin
         if (sel_read)
            spi_mode <= 1'b1;
         rd_hold      <= rd_sel;
         dum_left     <= spi_mode | sel_read;
         dat_left     <= ~sel_read;
         resp_valid_q <= 1'b0;
      end
      else
      begin
         resp_valid_q <= dum_left | dat_left;
         resp_data_q  <= dum_left ? DUMMY_BYTE : rd_hold;
         if (dum_left)
            dum_left <= 1'b0;
         else
            dat_left <= 1'b0;
      end
   end

   // ready drops for every taken request and while answering
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
         req_ready_q <= 1'b0;
      else
         req_ready_q <= hold_done & ~accept & ~dum_left & ~dat_left;
   end
endmodule

// ==== icl_host.sv ====
/*
 icl_host: host-side init sequencer with a payload FIFO in front.
 Assumes a device on icl_link_if.host and a byte source on the pay_* port.
*/
`timescale 1ns/10ps
module icl_fifo #(
   parameter int W = 8,
   parameter int D = 16
)(
   input  wire logic         clock_i,
   input  wire logic         resetn_i,
   // fill side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // drain side
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);

   if (D < 2 || (1 << AW) != D)
   begin : g_bad_depth
      $error("icl_fifo: depth must be a power of two");
   end

   logic [W-1:0] mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   count;

   wire push = in_valid_i & in_ready_o;
   wire pop  = out_ready_i & out_valid_o;
   wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   assign out_data_o = mem[rp];

   // flags registered so both handshakes come from flops
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wp          <= '0;
         rp          <= '0;
         count       <= '0;
         in_ready_o  <= 1'b0;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wp          <= wp + AW'(push);
         rp          <= rp + AW'(pop);
         count       <= next_count;
         in_ready_o  <= next_count != (AW+1)'(D);
         out_valid_o <= next_count != '0;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (push)
         mem[wp] <= in_data_i;
   end
endmodule

module icl_host #(
   parameter int PAYLOAD_BYTES = icl_pkg::PAYLOAD_BYTES,
   parameter int CHUNK_BYTES   = icl_pkg::PAYLOAD_BYTES,
   parameter int FIFO_DEPTH    = 16,
   parameter int ACCESS_CYC    = icl_pkg::ACCESS_DELAY_CYC,
   parameter int INIT_LIMIT    = icl_pkg::INIT_LIMIT_CYC
)(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   // device link
   icl_link_if.host         link,
   // control
   input  wire logic        start_i,
   input  wire logic        spi_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             fail_o,
   output logic [7:0]       part_id_o,
   // payload stream
   input  wire logic        pay_valid_i,
   input  wire logic [7:0]  pay_data_i,
   output logic             pay_ready_o
);
   import icl_pkg::*;

   localparam int CW = $clog2(PAYLOAD_BYTES) + 1;

   if (CHUNK_BYTES < 2 || CHUNK_BYTES % 2 != 0 || PAYLOAD_BYTES % CHUNK_BYTES != 0
       || PAYLOAD_BYTES > 131072 || ACCESS_CYC < 1 || ACCESS_CYC > 1048575
       || INIT_LIMIT < 1 || INIT_LIMIT > 1048575)
   begin : g_bad_param
      $error("icl_host: unsupported parameter value");
   end

   icl_hstate_t st;
   logic        spi;
   logic [19:0] timer;
   logic [15:0] woff;
   logic [CW-1:0] total;
   logic [CW-1:0] chunk;
   logic        rx_wait;
   logic [1:0]  rx_cnt;
   logic        req_valid_q;
   logic        req_write_q;
   logic [7:0]  req_addr_q;
   logic [7:0]  req_data_q;
   logic        f_valid;
   logic [7:0]  f_data;

   // request fields chosen by state
   wire is_read   = st == H_SELECT || st == H_ID || st == H_POLL;
   wire issues    = is_read || st == H_PS_OFF || st == H_PREPARE || st == H_ADDR_LO
                    || st == H_ADDR_HI || st == H_DATA || st == H_COMMIT;
   wire can_issue = issues & ~req_valid_q & ~rx_wait & (st != H_DATA | f_valid);
   wire f_pop     = can_issue & (st == H_DATA);
   wire accepted  = req_valid_q & link.req_ready;
   wire timer_out = timer == 20'h0_0000;
   wire [1:0] rx_need = (st == H_SELECT || !spi) ? 2'd1 : 2'd2;
   wire rx_last   = rx_wait & link.resp_valid & (rx_cnt == rx_need - 2'd1);
   wire [7:0] q_addr =
      (st == H_SELECT || st == H_ID) ? REG_PART_ID :
      st == H_PS_OFF  ? REG_POWER_CONFIGURATION_REGISTER :
      (st == H_PREPARE || st == H_COMMIT) ? REG_LOAD_CTRL :
      st == H_ADDR_LO ? REG_ADDR_LO :
      st == H_ADDR_HI ? REG_ADDR_HI :
      st == H_DATA    ? REG_DATA : REG_RESULT;
   wire [7:0] q_data =
      st == H_PREPARE ? LOAD_PREPARE :
      st == H_COMMIT  ? LOAD_COMMIT :
      st == H_ADDR_LO ? woff[7:0] :
      st == H_ADDR_HI ? woff[15:8] :
      st == H_DATA    ? f_data : POWER_CONFIGURATION_REGISTER_OPEN;

   assign link.req_valid = req_valid_q;
   assign link.req_write = req_write_q;
   assign link.req_spi   = spi;
   assign link.req_addr  = req_addr_q;
   assign link.req_data  = req_data_q;

   // payload bytes queue here while the link is busy
   icl_fifo #(
      .W (8),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (pay_valid_i),
      .in_data_i   (pay_data_i),
      .in_ready_o  (pay_ready_o),
      .out_valid_o (f_valid),
      .out_data_o  (f_data),
      .out_ready_i (f_pop)
   );

   // request register and answer counting
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         req_valid_q <= 1'b0;
         req_write_q <= 1'b0;
         req_addr_q  <= 8'h00;
         req_data_q  <= 8'h00;
         rx_wait     <= 1'b0;
         rx_cnt      <= 2'd0;
      end
      else if (can_issue)
      begin
         req_valid_q <= 1'b1;
         req_write_q <= ~is_read;
         req_addr_q  <= q_addr;
         req_data_q  <= q_data;
      end
      else if (accepted)
      begin
         req_valid_q <= 1'b0;
         rx_wait     <= ~req_write_q;
         rx_cnt      <= 2'd0;
      end
      else if (rx_wait && link.resp_valid)
      begin
         rx_cnt  <= rx_cnt + 2'd1;
         rx_wait <= ~rx_last;
      end
   end

   // init sequence
   always_ff @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st        <= H_IDLE;
         spi       <= 1'b0;
         timer     <= 20'h0_0000;
         woff      <= 16'h0000;
         total     <= '0;
         chunk     <= '0;
         busy_o    <= 1'b0;
         done_o    <= 1'b0;
         fail_o    <= 1'b0;
         part_id_o <= 8'h00;
      end
      else
      begin
         if (!timer_out)
            timer <= timer - 20'h0_0001;
         case (st)
            H_IDLE:
               if (start_i)
               begin
                  st     <= H_POWER;
                  spi    <= spi_i;
                  timer  <= 20'(ACCESS_CYC);
                  busy_o <= 1'b1;
                  done_o <= 1'b0;
                  fail_o <= 1'b0;
               end
            H_POWER:
               if (timer_out)
                  st <= spi ? H_SELECT : H_ID;
            H_SELECT:
               if (rx_last)
                  st <= H_ID;
            H_ID:
               if (rx_last)
               begin
                  part_id_o <= link.resp_data;
                  st        <= H_PS_OFF;
               end
            H_PS_OFF:
               if (accepted)
               begin
                  st    <= H_SETTLE;
                  timer <= 20'(ACCESS_CYC);
               end
            H_SETTLE:
               if (timer_out)
                  st <= H_PREPARE;
            H_PREPARE:
               if (accepted)
               begin
                  st    <= H_ADDR_LO;
                  woff  <= 16'h0000;
                  total <= '0;
               end
            H_ADDR_LO:
               if (accepted)
                  st <= H_ADDR_HI;
            H_ADDR_HI:
               if (accepted)
               begin
                  st    <= H_DATA;
                  chunk <= '0;
               end
            H_DATA:
               if (accepted)
               begin
                  total <= total + CW'(1);
                  chunk <= chunk + CW'(1);
                  if (total == CW'(PAYLOAD_BYTES - 1))
                     st <= H_COMMIT;
                  else if (chunk == CW'(CHUNK_BYTES - 1))
                  begin
                     woff <= woff + 16'(CHUNK_BYTES / 2);
                     st   <= H_ADDR_LO;
                  end
               end
            H_COMMIT:
               if (accepted)
               begin
                  st    <= H_POLL;
                  timer <= 20'(INIT_LIMIT);
               end
            H_POLL:
               if (rx_last && link.resp_data[3:0] == RESULT_OK)
               begin
                  st     <= H_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
               else if (timer_out && !req_valid_q && !rx_wait)
               begin
                  st     <= H_IDLE;
                  busy_o <= 1'b0;
                  fail_o <= 1'b1;
               end
            default:
               st <= H_IDLE;
         endcase
      end
   end
endmodule

// ==== icl_link_if.sv ====
/*
 icl_link_if: byte-level register access link between host and device.
 Abstracts SPI/I2C framing; req_spi marks an SPI-framed access.
*/
`timescale 1ns/10ps
interface icl_link_if;
   logic       req_valid;
   logic       req_ready;
   logic       req_write;
   logic       req_spi;
   logic [7:0] req_addr;
   logic [7:0] req_data;
   logic       resp_valid;
   logic [7:0] resp_data;

   modport dev (
      input  req_valid, req_write, req_spi, req_addr, req_data,
      output req_ready, resp_valid, resp_data
   );
   modport host (
      output req_valid, req_write, req_spi, req_addr, req_data,
      input  req_ready, resp_valid, resp_data
   );
endinterface

// ==== icl_pkg.sv ====
/*
 icl_pkg: shared constants and types for the init/config loader link.
 Assumes a 25 MHz device clock on both ends.
*/
package icl_pkg;
   // register map of the device end
   localparam logic [7:0] REG_TIME_LOW  = 8'h10;
   localparam logic [7:0] REG_RESULT    = 8'h11;
   localparam logic [7:0] REG_POWER_CONFIGURATION_REGISTER  = 8'h20;
   localparam logic [7:0] REG_LOAD_CTRL = 8'h21;
   localparam logic [7:0] REG_ADDR_LO   = 8'h22;
   localparam logic [7:0] REG_ADDR_HI   = 8'h23;
   localparam logic [7:0] REG_PART_ID   = 8'h24;
   localparam logic [7:0] REG_DATA      = 8'h26;
   localparam logic [7:0] REG_PWR_CTRL  = 8'h27;
   // field values
   localparam logic [7:0] LOAD_PREPARE   = 8'h00;
   localparam logic [7:0] LOAD_COMMIT    = 8'h01;
   localparam logic [7:0] POWER_CONFIGURATION_REGISTER_OPEN  = 8'h00;
   localparam logic [3:0] RESULT_NONE    = 4'h0;
   localparam logic [3:0] RESULT_OK      = 4'h1;
   localparam logic       PWR_SAVE_RST   = 1'b1;
   localparam logic [7:0] PWR_CTRL_RST   = 8'h00;
   localparam logic [7:0] DUMMY_BYTE     = 8'h00;
   localparam logic [7:0] PART_ID_VALUE  = 8'h5A; // arbitrary value
   localparam int         PAYLOAD_BYTES  = 8192;
   // timing
   localparam int CLK_PERIOD_NS     = 40;
   localparam int ACCESS_DELAY_US   = 450;
   localparam int ACCESS_DELAY_CYC  = (ACCESS_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIME_LSB_NS       = 37500;
   localparam int TIME_TICK_CYC     = (TIME_LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_LIMIT_MS     = 20;
   localparam int INIT_LIMIT_CYC    = INIT_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int FINALIZE_US       = 100;
   localparam int FINALIZE_CYC      = FINALIZE_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ICL_SUSPEND,
      ICL_LOADING,
      ICL_FINALIZE,
      ICL_CONFIG
   } icl_mode_t;

   typedef enum logic [3:0] {
      H_IDLE, H_POWER, H_SELECT, H_ID, H_PS_OFF, H_SETTLE, H_PREPARE,
      H_ADDR_LO, H_ADDR_HI, H_DATA, H_COMMIT, H_POLL
   } icl_hstate_t;
endpackage

// ==== tb_imu_init_config_loader.sv ====
/* tb_imu_init_config_loader: host and device joined by the link.
   Assumes shortened counts; a queue model follows the payload. */
`timescale 1ns/10ps
module tb_imu_init_config_loader;
   import icl_pkg::*;
   logic       clock_i = 1'b0;
   logic       resetn_i = 1'b0;
   logic       start_i = 1'b0;
   logic       spi_i = 1'b0;
   logic       pay_valid_i = 1'b0;
   logic [7:0] pay_data_i = 8'h00;
   logic       done, fail, pay_ready, cfg_done, pw_save, spi_mode;
   logic [7:0] part_id;
   logic       busy;
   logic [7:0] pwr_ctl;
   int         n_commit = 0;
   icl_mode_t  mode;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         nw = 0;
   logic [7:0] q[$];
   icl_link_if lnk();
   icl_device #(.PAYLOAD_BYTES(64), .ACCESS_CYC(20)) icl_device_inst (
      .clock_i(clock_i), .resetn_i(resetn_i), .link(lnk.dev), .mode_o(mode),
      .power_save_o(pw_save), .spi_mode_o(spi_mode), .config_done_o(cfg_done),
      .pwr_ctrl_o(pwr_ctl));
   icl_host #(.PAYLOAD_BYTES(64), .CHUNK_BYTES(16), .ACCESS_CYC(20))
   icl_host_inst (.clock_i(clock_i), .resetn_i(resetn_i), .link(lnk.host), .start_i(start_i),
      .spi_i(spi_i), .busy_o(busy), .done_o(done), .fail_o(fail), .part_id_o(part_id),
      .pay_valid_i(pay_valid_i), .pay_data_i(pay_data_i), .pay_ready_o(pay_ready));
   icl_checker icl_checker_inst (.clock_i(clock_i), .resetn_i(resetn_i),
      .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .req_write(lnk.req_write),
      .req_spi(lnk.req_spi), .req_addr(lnk.req_addr), .req_data(lnk.req_data),
      .resp_valid(lnk.resp_valid), .resp_data(lnk.resp_data));
   always #20 clock_i = ~clock_i;
   task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // model: bytes leave in arrival order, offsets follow the bytes sent
   always @(posedge clock_i)
   begin
      if (pay_valid_i && pay_ready) q.push_back(pay_data_i);
      if (lnk.req_valid && lnk.req_ready && lnk.req_write)
      begin
         if (lnk.req_addr == REG_DATA) chk("data", q.pop_front(), lnk.req_data);
         if (lnk.req_addr == REG_ADDR_LO) chk("offset", 8'(nw / 2), lnk.req_data);
         if (lnk.req_addr == REG_POWER_CONFIGURATION_REGISTER) chk("pwr", POWER_CONFIGURATION_REGISTER_OPEN, lnk.req_data);
         if (lnk.req_addr == REG_LOAD_CTRL)
            chk("load", nw == 64 ? LOAD_COMMIT : LOAD_PREPARE, lnk.req_data);
         if (lnk.req_addr == REG_DATA) nw++;
         if (lnk.req_addr == REG_LOAD_CTRL && lnk.req_data == LOAD_COMMIT) n_commit++;
      end
   end
   // random gaps starve the fifo; host waits let it fill and refuse
   task feed;
      int k;
      int st;
      for (int i = 0; i < 64; i++)
      begin
         pay_data_i = 8'($urandom);
         pay_valid_i = 1'b1;
         for (k = 0; k < 4000; k++)
         begin
            @(posedge clock_i);
            if (pay_ready === 1'b1) break;
         end
         #1;
         if (k >= 4000)
         begin
            chk("feed", 8'h01, 8'h00);
            report_and_stop;
         end
         st = $urandom % 3;
         if (st > 0) pay_valid_i = 1'b0;
         repeat (st) @(posedge clock_i);
         if (st > 0) #1;
      end
      pay_valid_i = 1'b0;
   endtask
   task run(input logic s);
      int k;
      resetn_i = 1'b0;
      nw = 0;
      n_commit = 0;
      q.delete();
      repeat (8) @(posedge clock_i);
      #1;
      chk("save", 8'(PWR_SAVE_RST), 8'(pw_save));
      chk("mode", 8'(ICL_SUSPEND), 8'(mode));
      resetn_i = 1'b1;
      spi_i = s;
      @(posedge clock_i);
      #1;
      start_i = 1'b1;
      @(posedge clock_i);
      #1;
      start_i = 1'b0;
      fork
         feed();
      join_none
      for (k = 0; k < 8000 && done !== 1'b1 && fail !== 1'b1; k++) @(posedge clock_i);
      #1;
      if (k >= 8000)
      begin
         chk("wait", 8'h01, 8'h00);
         report_and_stop;
      end
      chk("done", 8'h01, 8'(done));
      chk("fail", 8'h00, 8'(fail));
      chk("cfg", 8'h01, 8'(cfg_done));
      chk("mode", 8'(ICL_CONFIG), 8'(mode));
      chk("save", 8'h00, 8'(pw_save));
      chk("part", PART_ID_VALUE, part_id);
      chk("spi", 8'(s), 8'(spi_mode));
      chk("left", 8'h00, 8'(q.size()));
      chk("busy", 8'h00, 8'(busy));
      chk("pctl", PWR_CTRL_RST, pwr_ctl);
      chk("commits", 8'h01, 8'(n_commit));
   endtask
   initial
   begin
      void'($urandom(54703));
      #1;
      run(1'b0);
      run(1'b1);
      report_and_stop;
   end
endmodule
